// ===== dacpc_core.sv
// Conversion timing, serial readout, echo clock and nap/sleep control.
// Assumes strobe, serial clock and straps are pins sampled by clk_sys,
// and the analog core answers convert_start with core_done and results.
`timescale 1ns/1ps
module dacpc_core
  import dacpc_pkg::*;
(
  input  wire logic                    clk_sys,               // System clock
  input  wire logic                    rst,                   // Power-on reset, active high
  input  wire logic                    conversion_strobe,     // Strobe pin
  input  wire logic                    serial_clock,          // Serial clock pin
  input  wire logic                    echo_disable_strap,    // High turns echo clock off
  input  wire logic                    reference_buffer_strap,// High enables ref buffer
  input  wire logic                    io_standard_select,    // High selects differential
  input  wire logic                    core_done,             // Core result ready, pulse
  input  wire logic [RESULT_WIDTH-1:0] core_result_one,       // Channel one result
  input  wire logic [RESULT_WIDTH-1:0] core_result_two,       // Channel two result
  output logic                         sample_start,          // Start sampling, pulse
  output logic                         convert_start,         // Start conversion, pulse
  output logic                         data_lane_one,         // Serial data, channel one
  output logic                         data_lane_two,         // Serial data, channel two
  output logic                         echo_clock,            // Echo of serial clock
  output logic                         echo_clock_en,         // Echo output enable
  output logic                         reference_buffer_en,   // Reference buffer on
  output logic                         lanes_differential,    // Differential signalling
  output logic                         nap_active,            // Device in nap
  output logic                         sleep_active           // Device in sleep
);

  // Synchronised pins
  logic strobe_level;
  logic strobe_rise;
  logic strobe_fall;
  logic sclk_level;
  logic sclk_rise;
  logic sclk_fall;
  logic echo_off;
  logic ref_on;
  logic diff_sel;

  dacpc_sync_edge u_sync_strobe (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (conversion_strobe),
    .level   (strobe_level),
    .rise    (strobe_rise),
    .fall    (strobe_fall)
  );

  // Serial clock is only sampled; its edges pace the readout
  dacpc_sync_edge u_sync_sclk (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (serial_clock),
    .level   (sclk_level),
    .rise    (sclk_rise),
    .fall    (sclk_fall)
  );

  dacpc_sync_edge u_sync_echo_strap (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (echo_disable_strap),
    .level   (echo_off),
    .rise    (),
    .fall    ()
  );

  dacpc_sync_edge u_sync_ref_strap (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (reference_buffer_strap),
    .level   (ref_on),
    .rise    (),
    .fall    ()
  );

  dacpc_sync_edge u_sync_io_sel (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (io_standard_select),
    .level   (diff_sel),
    .rise    (),
    .fall    ()
  );

  function automatic logic [RESULT_WIDTH-1:0] shift_out(
    input logic [RESULT_WIDTH-1:0] word
  );
    shift_out = {word[RESULT_MSB-1:0], 1'b0};
  endfunction

  // Power state
  dacpc_power_type        power_q;
  dacpc_power_type        power_d;
  logic [COUNT_WIDTH-1:0] pulse_cnt_q;
  logic [COUNT_WIDTH-1:0] pulse_cnt_d;
  logic [COUNT_WIDTH-1:0] pulse_cnt_inc;
  logic                   sclk_wakes;

  assign pulse_cnt_inc = pulse_cnt_q + COUNT_ONE;

  // Differential mode cannot wake from sleep on the serial clock
  assign sclk_wakes = (power_q != PWR_SLEEP) | ~diff_sel;

  always_comb begin
    power_d     = power_q;
    pulse_cnt_d = pulse_cnt_q;
    if (sclk_rise) begin
      if (sclk_wakes) begin
        power_d     = PWR_OPER;
        pulse_cnt_d = COUNT_ZERO;
      end
    end else if (strobe_rise) begin
      pulse_cnt_d = pulse_cnt_inc;
      unique case (pulse_cnt_inc)
        NAP_COUNT:   power_d = PWR_NAP;
        SLEEP_COUNT: power_d = PWR_SLEEP;
        WAKE_COUNT: begin
          power_d     = PWR_OPER;
          pulse_cnt_d = COUNT_ZERO;
        end
        default: power_d = power_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_q     <= PWR_OPER;
      pulse_cnt_q <= COUNT_ZERO;
    end else begin
      power_q     <= power_d;
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  // Conversion timing
  logic sample_q;
  logic convert_q;
  logic armed_q;
  logic do_sample;
  logic do_convert;

  // A strobe that itself ends in nap still samples; nap only stops later ones
  assign do_sample  = strobe_rise & (power_q == PWR_OPER);
  assign do_convert = strobe_fall & armed_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sample_q  <= 1'b0;
      convert_q <= 1'b0;
      armed_q   <= 1'b0;
    end else begin
      sample_q  <= do_sample;
      convert_q <= do_convert;
      if (do_sample) begin
        armed_q <= 1'b1;
      end else if (strobe_fall) begin
        armed_q <= 1'b0;
      end
    end
  end

  // Readout: previous result goes out, giving one cycle of latency
  logic [RESULT_WIDTH-1:0] hold_one_q;
  logic [RESULT_WIDTH-1:0] hold_two_q;
  logic [RESULT_WIDTH-1:0] shift_one_q;
  logic [RESULT_WIDTH-1:0] shift_two_q;
  logic                    lane_one_q;
  logic                    lane_two_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_one_q  <= RESULT_RESET;
      hold_two_q  <= RESULT_RESET;
      shift_one_q <= RESULT_RESET;
      shift_two_q <= RESULT_RESET;
      lane_one_q  <= 1'b0;
      lane_two_q  <= 1'b0;
    end else begin
      if (core_done) begin
        hold_one_q <= core_result_one;
        hold_two_q <= core_result_two;
      end
      if (do_convert) begin
        shift_one_q <= hold_one_q;
        shift_two_q <= hold_two_q;
      end else if (sclk_fall) begin
        lane_one_q  <= shift_one_q[RESULT_MSB];
        lane_two_q  <= shift_two_q[RESULT_MSB];
        shift_one_q <= shift_out(shift_one_q);
        shift_two_q <= shift_out(shift_two_q);
      end
    end
  end

  // Echo clock: same register stage as the lanes keeps skew matched
  logic echo_q;
  logic echo_en_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      echo_q    <= 1'b0;
      echo_en_q <= 1'b0;
    end else begin
      echo_en_q <= ~echo_off;
      echo_q    <= sclk_level & ~echo_off;
    end
  end

  // Strap-driven configuration, registered from the synchronised straps every cycle after reset release
  logic ref_en_q;
  logic diff_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_en_q <= 1'b0;
      diff_q   <= 1'b0;
    end else begin
      ref_en_q <= ref_on;
      diff_q   <= diff_sel;
    end
  end

  assign sample_start        = sample_q;
  assign convert_start       = convert_q;
  assign data_lane_one       = lane_one_q;
  assign data_lane_two       = lane_two_q;
  assign echo_clock          = echo_q;
  assign echo_clock_en       = echo_en_q;
  assign reference_buffer_en = ref_en_q;
  assign lanes_differential  = diff_q;
  assign nap_active          = (power_q == PWR_NAP);
  assign sleep_active        = (power_q == PWR_SLEEP);

endmodule

// ===== dacpc_pkg.sv
// Constants and types shared by the dual converter power and readout control.
// Assumes every user sits on the clk_sys domain.
package dacpc_pkg;

  localparam int unsigned RESULT_WIDTH = 16;
  localparam int unsigned RESULT_MSB   = RESULT_WIDTH - 1;
  localparam int unsigned COUNT_WIDTH  = 3;

  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO  = 3'h0;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ONE   = 3'h1;
  localparam logic [COUNT_WIDTH-1:0] NAP_COUNT   = 3'h2;
  localparam logic [COUNT_WIDTH-1:0] SLEEP_COUNT = 3'h4;
  localparam logic [COUNT_WIDTH-1:0] WAKE_COUNT  = 3'h5;

  localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    PWR_OPER,
    PWR_NAP,
    PWR_SLEEP
  } dacpc_power_type;

endpackage

// ===== dacpc_sync_edge.sv
// Two-stage synchroniser with edge pulses for one pin input.
// Assumes the pin is asynchronous to clk_sys and slower than half its rate.
`timescale 1ns/1ps
module dacpc_sync_edge (
  input  wire logic clk_sys,     // System clock
  input  wire logic rst,         // Async reset, active high
  input  wire logic pin_in,      // Asynchronous pin level
  output logic      level,       // Synchronised level
  output logic      rise,        // One-cycle pulse on rising edge
  output logic      fall         // One-cycle pulse on falling edge
);

  logic       meta_q;
  logic       sync_q;
  logic       last_q;
  logic [2:0] fill_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      fill_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  // Edges come from the second and third stages only
  // No edges until all stages hold pin samples: a pin idling high gives no false edge
  assign level = sync_q;
  assign rise  = sync_q & ~last_q & fill_q[2];
  assign fall  = ~sync_q & last_q & fill_q[2];

endmodule

// ===== dacpc_core_checker.sv
// Port assertions for dacpc_core, bound to every instance.
// Assumes pins hold each level at least two clk_sys cycles.
`timescale 1ns/1ps
module dacpc_core_checker (
  input wire logic clk_sys,                // Clock
  input wire logic rst,                    // Reset
  input wire logic serial_clock,           // Pin
  input wire logic reference_buffer_strap, // Pin
  input wire logic sample_start,           // Pulse
  input wire logic convert_start,          // Pulse
  input wire logic data_lane_one,          // Lane
  input wire logic data_lane_two,          // Lane
  input wire logic echo_clock,             // Echo
  input wire logic echo_clock_en,          // Echo on
  input wire logic reference_buffer_en,    // Buffer on
  input wire logic nap_active,             // Nap
  input wire logic sleep_active            // Sleep
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Six calm samples outlast the sync and output stages
  sequence steady(s);
    $stable(s) [*6];
  endsequence
  AST_SAMPLE_OPER: assert property (sample_start |-> !$past(nap_active) && !$past(sleep_active))
    else $error("sample pulse outside operation");
  AST_SAMPLE_PULSE: assert property (sample_start |=> !sample_start)
    else $error("sample pulse too long");
  AST_CONV_PULSE: assert property (convert_start |=> !convert_start)
    else $error("convert pulse too long");
  AST_STATE_EXCL: assert property (!(nap_active && sleep_active))
    else $error("nap and sleep together");
  AST_SLEEP_FROM_NAP: assert property ($rose(sleep_active) |-> $past(nap_active))
    else $error("sleep entered not from nap");
  AST_NAP_FROM_OPER: assert property ($rose(nap_active) |-> !$past(sleep_active))
    else $error("nap entered not from operation");
  AST_LANES_HOLD: assert property (steady(serial_clock) |-> $stable({data_lane_one, data_lane_two}))
    else $error("lanes moved without serial clock fall");
  AST_ECHO_FOLLOW: assert property (steady(serial_clock) ##0 echo_clock_en |-> echo_clock == serial_clock)
    else $error("echo clock not following");
  AST_REF_STRAP: assert property (steady(reference_buffer_strap) |-> reference_buffer_en == reference_buffer_strap)
    else $error("reference buffer not following strap");
endmodule
bind dacpc_core dacpc_core_checker u_checker (.clk_sys, .rst, .serial_clock,
  .reference_buffer_strap, .sample_start, .convert_start, .data_lane_one, .data_lane_two,
  .echo_clock, .echo_clock_en, .reference_buffer_en, .nap_active, .sleep_active);

// ===== dacpc_host.sv
// Host pin model: strobe and serial clock driver, lane capture.
// Assumes calls start just after a clk_sys edge; 8 cycles a serial clock.
`timescale 1ns/1ps
module dacpc_host (
  input  wire logic clk_sys,  // Clock
  input  wire logic lane_one, // Lane in
  input  wire logic lane_two, // Lane in
  output logic      strobe,   // Strobe pin
  output logic      sclk      // Serial clock pin
);
  initial begin
    strobe = 1'b0;
    sclk   = 1'b1;
  end
  // Four cycles a level keeps each edge clear of the sync stages
  task automatic pulse();
    @(posedge clk_sys);
    strobe <= 1'b1;
    repeat (4) @(posedge clk_sys);
    strobe <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic cycle();
    @(posedge clk_sys);
    sclk <= 1'b0;
    repeat (4) @(posedge clk_sys);
    sclk <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic read_word(output logic [15:0] a, output logic [15:0] b);
    for (int i = 0; i < 16; i++) begin
      cycle();
      a = {a[14:0], lane_one};
      b = {b[14:0], lane_two};
    end
  endtask
endmodule

// ===== dual_adc_conversion_power_control_tb.sv
// Bench for dacpc_core: host pin model, core stand-in, state model.
// Assumes clk_sys at 10 MHz and serial clock idle high between frames.
`timescale 1ns/1ps
module dual_adc_conversion_power_control_tb;
  import dacpc_pkg::*;
  logic clk_sys, rst, conversion_strobe, serial_clock, core_done, echo_disable_strap;
  logic reference_buffer_strap, io_standard_select, sample_start, convert_start;
  logic data_lane_one, data_lane_two, echo_clock, echo_clock_en, reference_buffer_en;
  logic lanes_differential, nap_active, sleep_active;
  logic [RESULT_WIDTH-1:0] core_result_one, core_result_two, exp1, exp2, got1, got2;
  logic [2*RESULT_WIDTH-1:0] pair;
  logic [2*RESULT_WIDTH-1:0] pend[$];
  int fail_count, n_compared, n_samp, n_conv, exp_samp, cnt;
  dacpc_power_type st;
  dacpc_core dut (.clk_sys, .rst, .conversion_strobe, .serial_clock, .echo_disable_strap,
    .reference_buffer_strap, .io_standard_select, .core_done, .core_result_one,
    .core_result_two, .sample_start, .convert_start, .data_lane_one, .data_lane_two,
    .echo_clock, .echo_clock_en, .reference_buffer_en, .lanes_differential, .nap_active,
    .sleep_active);
  dacpc_host host (.clk_sys, .lane_one(data_lane_one), .lane_two(data_lane_two),
    .strobe(conversion_strobe), .sclk(serial_clock));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Core stand-in; a new result only shows on the next readout, so one pair waits in line
  always @(posedge clk_sys) begin
    core_done <= 1'b0;
    if (rst) begin
      pend.delete();
      pend.push_back({RESULT_RESET, RESULT_RESET});
    end else begin
      if (sample_start === 1'b1) n_samp++;
      if (convert_start === 1'b1) begin
        n_conv++;
        {exp1, exp2} = pend.pop_front();
        pair = {RESULT_WIDTH'($urandom), RESULT_WIDTH'($urandom)};
        pend.push_back(pair);
        {core_result_one, core_result_two} <= pair;
        core_done <= 1'b1;
      end
    end
  end
  task automatic check_word(input logic [RESULT_WIDTH-1:0] got,
                            input logic [RESULT_WIDTH-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_count(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic look();
    check_flag(nap_active, st == PWR_NAP);
    check_flag(sleep_active, st == PWR_SLEEP);
  endtask
  task automatic strobe_p();
    if (st == PWR_OPER) exp_samp++;
    host.pulse();
    cnt++;
    if (cnt == 2) st = PWR_NAP;
    if (cnt == 4) st = PWR_SLEEP;
    if (cnt == 5) st = PWR_OPER;
    if (cnt == 5) cnt = 0;
    look();
  endtask
  task automatic wake();
    host.cycle();
    // State register takes the detected rise at this very edge; look one edge later
    @(posedge clk_sys);
    if (st != PWR_SLEEP || !io_standard_select) begin
      st = PWR_OPER;
      cnt = 0;
    end
    look();
  endtask
  task automatic convert();
    strobe_p();
    host.read_word(got1, got2);
    cnt = 0;
    check_word(got1, exp1);
    check_word(got2, exp2);
  endtask
  initial begin
    rst <= 1'b1;
    echo_disable_strap <= 1'b0;
    reference_buffer_strap <= 1'b1;
    io_standard_select <= 1'b0;
    st = PWR_OPER;
    void'($urandom(42232));
    repeat (12) @(posedge clk_sys);
    // Supply and reference settling waits are scaled away; the logic never sees them
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      echo_disable_strap <= i[0];
      reference_buffer_strap <= i[1];
      repeat (6) @(posedge clk_sys);
      check_flag(echo_clock_en, !echo_disable_strap);
      check_flag(echo_clock, !echo_disable_strap);
      check_flag(reference_buffer_en, reference_buffer_strap);
      check_flag(lanes_differential, io_standard_select);
      convert();
      convert();
    end
    // Serial clock toggles only in wake and convert from here: strobes alone step the state
    repeat (7) strobe_p();
    wake();
    repeat (4) strobe_p();
    wake();
    io_standard_select <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check_flag(lanes_differential, io_standard_select);
    repeat (4) strobe_p();
    wake();
    strobe_p();
    convert();
    check_count(n_samp, exp_samp);
    check_count(n_conv, exp_samp);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    test_done();
  end
endmodule
